// file: verilog/deid_edge_irq_diag.v
// Two-channel input filter, edge process interrupt and diagnostic record
// Assumes one 100 MHz clock, inputs asynchronous, host logic on sys_clk
//
// What this block does
// [R1] Diagnostic function off with enable byte 00h, on with 40h.
// [R2] Per-channel delay code: 00h,02h,04h,07h,09h,0Ch; other codes not used.
// [R3] Rising-edge enable byte: bit 0 channel 0, bit 1 channel 1.
// [R4] Falling-edge enable byte: bit 0 channel 0, bit 1 channel 1.
// [R5] Interrupt record byte 0 flags the channel that fired.
// [R6] Interrupt record byte 1 snapshots both input states at the event.
// [R7] Interrupt record timestamp is low 16 ticker bits at the event.
// [R8] 32-bit microsecond ticker from zero at reset, wraps to zero.
// [R9] Going notice issued automatically once the diagnostic cause is gone.
// [R10] Channel events between incoming and going notices are dropped.
// [R11] Fault LED lit from incoming until going notice.
// [R12] Summary byte: bit0 module failure, bit2 external, bit3 channel error.
// [R13] Class byte reads 1Fh: digital class with channel information.
// [R14] Internal byte bit 3 flags buffer overflow; raises diagnostic, set only with diagnostic on.
// [R15] Internal byte bit 6 flags lost process interrupt; raises diagnostic.
// [R16] Record reports channel kind 70h, 00h bits per channel, 2 channels.
// [R17] Long request returns whole record, short request first four bytes.
// [R18] Record holds 32-bit ticker copy latched at the diagnostic event.
// [R19] Channel fault byte: bit 0 edge lost ch0, bit 1 edge lost ch1.
// [R20] Host may write diagnostic enable at any time, mid-run included; the block has no stopped-state check.
// [R21] Filter passes a level only after stable for the selected delay.
// [R22] Edge while record pending sets lost flag only with diagnostic on; keeps pending record.
// [R23] Reserved bits read zero; writes to them are ignored.
`default_nettype none
`include "deid_map.vh"

module deid_edge_irq_diag #(
    parameter [18:0] DLY_86US_CYC   = `DEID_T_86US * `DEID_CLK_MHZ,
    parameter [18:0] DLY_342US_CYC  = `DEID_T_342US * `DEID_CLK_MHZ,
    parameter [18:0] DLY_2731US_CYC = `DEID_T_2731US * `DEID_CLK_MHZ,
    parameter [6:0]  US_CYC         = `DEID_US_CYC
) (
    input  wire        sys_clk,
    input  wire        sys_rst,
    input  wire [1:0]  input_channel,
    input  wire        param_wr_en,
    input  wire [2:0]  param_idx,
    input  wire [7:0]  param_wdata,
    input  wire        proc_irq_ack,
    input  wire        diag_ack,
    input  wire        rec_rd_en,
    input  wire        rec_long,
    input  wire [4:0]  rec_idx,
    output reg  [1:0]  input_state_ff,
    output reg         proc_irq_pend_ff,
    output reg  [7:0]  proc_irq_source_ff,
    output reg  [7:0]  proc_irq_input_snapshot_ff,
    output reg  [15:0] proc_irq_timestamp_ff,
    output reg         diag_incoming_ff,
    output reg         diag_going_ff,
    output reg         module_fault_led_ff,
    output reg  [7:0]  rec_rdata_ff,
    output reg         rec_valid_ff,
    output reg         rec_err_ff,
    output reg  [31:0] ticker_ff
);

    localparam [18:0] DLY_1US_CYC  = `DEID_T_1US * `DEID_CLK_MHZ;
    localparam [18:0] DLY_3US_CYC  = `DEID_T_3US * `DEID_CLK_MHZ;
    localparam [18:0] DLY_10US_CYC = `DEID_T_10US * `DEID_CLK_MHZ;

    localparam ST_QUIET  = 1'b0;
    localparam ST_ACTIVE = 1'b1;

    // ***********************************************
    // Delay code to stable-time count
    // ***********************************************
    function [18:0] delay_cycles;
        input [7:0] code;
        begin
            case (code)
                `DEID_DLY_1US:    delay_cycles = DLY_1US_CYC;
                `DEID_DLY_3US:    delay_cycles = DLY_3US_CYC;
                `DEID_DLY_10US:   delay_cycles = DLY_10US_CYC;
                `DEID_DLY_86US:   delay_cycles = DLY_86US_CYC;
                `DEID_DLY_342US:  delay_cycles = DLY_342US_CYC;
                `DEID_DLY_2731US: delay_cycles = DLY_2731US_CYC;
                default:          delay_cycles = DLY_3US_CYC;
            endcase
        end
    endfunction

    function code_ok;
        input [7:0] code;
        begin
            case (code)
                `DEID_DLY_1US, `DEID_DLY_3US, `DEID_DLY_10US,
                `DEID_DLY_86US, `DEID_DLY_342US, `DEID_DLY_2731US:
                    code_ok = 1'b1;
                default:
                    code_ok = 1'b0;
            endcase
        end
    endfunction

    reg  [1:0]  sync1_ff;
    reg  [1:0]  sync2_ff;
    reg  [18:0] flt_cnt_ff [0:1];
    reg  [7:0]  delay_ff [0:1];
    reg         diag_interrupt_enable_ff;
    reg  [1:0]  rise_en_ff;
    reg  [1:0]  fall_en_ff;
    reg  [6:0]  presc_ff;
    reg         diag_state_ff;
    reg         lost_ff;
    reg         overflow_ff;
    reg  [1:0]  ch_fault_ff;
    reg  [31:0] diag_ts_ff;

    reg  [1:0]  nxt_state;
    reg  [1:0]  fired;
    reg  [1:0]  nxt_level;
    integer     i, j;

    // ***********************************************
    // Input synchroniser
    // ***********************************************
    always @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            sync1_ff <= 2'h0;
            sync2_ff <= 2'h0;
        end
        else
        begin
            sync1_ff <= input_channel;
            sync2_ff <= sync1_ff;
        end
    end

    // ***********************************************
    // Parameter bytes
    // ***********************************************
    always @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            diag_interrupt_enable_ff  <= 1'b0;
            delay_ff[0] <= `DEID_RST_DELAY;
            delay_ff[1] <= `DEID_RST_DELAY;
            rise_en_ff  <= 2'h0;
            fall_en_ff  <= 2'h0;
        end
        else if (param_wr_en)
        begin
            case (param_idx)
                `DEID_PIDX_DIAG_INTERRUPT_ENABLE:
                    if (param_wdata == `DEID_DIAG_ON ||
                        param_wdata == `DEID_DIAG_OFF)
                        diag_interrupt_enable_ff <= param_wdata[`DEID_DIAG_INTERRUPT_ENABLE_BIT]; // [R1]
                `DEID_PIDX_DELAY0:
                    if (code_ok(param_wdata))
                        delay_ff[0] <= param_wdata; // [R2]
                `DEID_PIDX_DELAY1:
                    if (code_ok(param_wdata))
                        delay_ff[1] <= param_wdata; // [R2]
                `DEID_PIDX_RISE_EN:
                    rise_en_ff <= param_wdata[1:0]; // [R3] [R23]
                `DEID_PIDX_FALL_EN:
                    fall_en_ff <= param_wdata[1:0]; // [R4] [R23]
                default:
                    ;
            endcase
        end
    end

    // ***********************************************
    // Microsecond ticker
    // ***********************************************
    always @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            presc_ff  <= 7'h00;
            ticker_ff <= 32'h0000_0000;
        end
        else if (presc_ff == US_CYC - 7'h01)
        begin
            presc_ff  <= 7'h00;
            ticker_ff <= ticker_ff + 32'h0000_0001; // [R8]
        end
        else
        begin
            presc_ff <= presc_ff + 7'h01;
        end
    end

    // ***********************************************
    // Input filters
    // ***********************************************
    always @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            input_state_ff <= 2'h0;
            flt_cnt_ff[0]  <= 19'h0_0000;
            flt_cnt_ff[1]  <= 19'h0_0000;
        end
        else
        begin
            for (i = 0; i < 2; i = i + 1)
            begin
                if (sync2_ff[i] == input_state_ff[i])
                    flt_cnt_ff[i] <= 19'h0_0000;
                else if (flt_cnt_ff[i] + 19'h0_0001 >=
                         delay_cycles(delay_ff[i]))
                begin
                    input_state_ff[i] <= sync2_ff[i]; // [R21]
                    flt_cnt_ff[i]     <= 19'h0_0000;
                end
                else
                    flt_cnt_ff[i] <= flt_cnt_ff[i] + 19'h0_0001;
            end
        end
    end

    // ***********************************************
    // Edge detection on filtered levels
    // ***********************************************
    always @*
    begin
        fired = 2'h0;
        nxt_level = input_state_ff;
        for (j = 0; j < 2; j = j + 1)
        begin
            if (flt_cnt_ff[j] + 19'h0_0001 >= delay_cycles(delay_ff[j]) &&
                sync2_ff[j] != input_state_ff[j])
            begin
                nxt_level[j] = sync2_ff[j];
                if (sync2_ff[j] && rise_en_ff[j])
                    fired[j] = 1'b1; // [R3] [R21]
                if (!sync2_ff[j] && fall_en_ff[j])
                    fired[j] = 1'b1; // [R4]
            end
        end
        if (diag_state_ff == ST_ACTIVE)
            fired = 2'h0; // [R10]
    end

    // ***********************************************
    // Process interrupt record
    // ***********************************************
    always @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            proc_irq_pend_ff           <= 1'b0;
            proc_irq_source_ff         <= 8'h00;
            proc_irq_input_snapshot_ff <= 8'h00;
            proc_irq_timestamp_ff      <= 16'h0000;
        end
        else if (fired != 2'h0 && (!proc_irq_pend_ff || proc_irq_ack))
        begin
            proc_irq_pend_ff           <= 1'b1;
            proc_irq_source_ff         <= {6'h00, fired}; // [R5]
            proc_irq_input_snapshot_ff <= {6'h00, nxt_level}; // [R6]
            proc_irq_timestamp_ff      <= ticker_ff[15:0]; // [R7]
        end
        else if (proc_irq_ack)
        begin
            proc_irq_pend_ff <= 1'b0;
        end
    end

    // ***********************************************
    // Diagnostic flags
    // ***********************************************
    wire       lost_evt = diag_interrupt_enable_ff && proc_irq_pend_ff &&
                          !proc_irq_ack && (fired != 2'h0); // [R22]
    wire       ovf_evt  = lost_evt && lost_ff && !diag_ack;
    wire       cause    = lost_ff || overflow_ff;

    always @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            lost_ff     <= 1'b0;
            overflow_ff <= 1'b0;
            ch_fault_ff <= 2'h0;
        end
        else
        begin
            if (lost_evt)
                lost_ff <= 1'b1; // [R15]
            else if (diag_ack)
                lost_ff <= 1'b0;
            if (ovf_evt)
                overflow_ff <= 1'b1; // [R14]
            else if (diag_ack)
                overflow_ff <= 1'b0;
            if (lost_evt)
                ch_fault_ff <= ch_fault_ff | fired; // [R19]
            else if (diag_ack)
                ch_fault_ff <= 2'h0;
        end
    end

    // ***********************************************
    // Incoming and going notices
    // ***********************************************
    always @*
    begin
        nxt_state = {1'b0, diag_state_ff};
        case (diag_state_ff)
            ST_QUIET:
                if (cause)
                    nxt_state = {1'b1, ST_ACTIVE};
            ST_ACTIVE:
                if (!cause)
                    nxt_state = {1'b1, ST_QUIET}; // [R9]
            default:
                nxt_state = {1'b0, ST_QUIET};
        endcase
    end

    always @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            diag_state_ff       <= ST_QUIET;
            diag_incoming_ff    <= 1'b0;
            diag_going_ff       <= 1'b0;
            module_fault_led_ff <= 1'b0;
            diag_ts_ff          <= 32'h0000_0000;
        end
        else
        begin
            diag_state_ff       <= nxt_state[0];
            diag_incoming_ff    <= nxt_state[1] && nxt_state[0];
            diag_going_ff       <= nxt_state[1] && !nxt_state[0]; // [R9]
            module_fault_led_ff <= nxt_state[0]; // [R11]
            if (nxt_state[1] && nxt_state[0])
                diag_ts_ff <= ticker_ff; // [R18]
        end
    end

    // ***********************************************
    // Diagnostic record read
    // ***********************************************
    always @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            rec_rdata_ff <= 8'h00;
            rec_valid_ff <= 1'b0;
            rec_err_ff   <= 1'b0;
        end
        else
        begin
            rec_valid_ff <= rec_rd_en;
            rec_err_ff   <= 1'b0;
            rec_rdata_ff <= 8'h00; // [R23]
            if (rec_rd_en)
            begin
                if ((!rec_long && rec_idx > `DEID_SHORT_LAST) ||
                    rec_idx > `DEID_RIDX_TS3)
                    rec_err_ff <= 1'b1; // [R17]
                else
                    case (rec_idx)
                        `DEID_RIDX_SUMMARY:
                            rec_rdata_ff <= {4'h0,
                                ch_fault_ff != 2'h0, 1'b0, 1'b0,
                                overflow_ff}; // [R12]
                        `DEID_RIDX_CLASS:
                            rec_rdata_ff <= `DEID_CLASS_INFO; // [R13]
                        `DEID_RIDX_INTERNAL:
                            rec_rdata_ff <= {1'b0, lost_ff, 2'h0,
                                overflow_ff, 3'h0}; // [R14] [R15]
                        `DEID_RIDX_CHKIND:
                            rec_rdata_ff <= `DEID_CHANNEL_KIND; // [R16]
                        `DEID_RIDX_BITS:
                            rec_rdata_ff <= `DEID_BITS_PER_CH; // [R16]
                        `DEID_RIDX_CHCOUNT:
                            rec_rdata_ff <= `DEID_CHANNEL_COUNT; // [R16]
                        `DEID_RIDX_CHFAULT:
                            rec_rdata_ff <= {6'h00, ch_fault_ff}; // [R19]
                        5'h10:
                            rec_rdata_ff <= diag_ts_ff[7:0]; // [R18]
                        5'h11:
                            rec_rdata_ff <= diag_ts_ff[15:8];
                        5'h12:
                            rec_rdata_ff <= diag_ts_ff[23:16];
                        `DEID_RIDX_TS3:
                            rec_rdata_ff <= diag_ts_ff[31:24];
                        default:
                            rec_rdata_ff <= 8'h00;
                    endcase
            end
        end
    end

endmodule // deid_edge_irq_diag
`default_nettype wire

// file: verilog/deid_map.vh
// Constants for the two-channel edge interrupt and diagnostic block
// Assumes inclusion by bare name from the design file
`ifndef DEID_MAP_VH
`define DEID_MAP_VH

// ***********************************************
// Parameter byte indices
// ***********************************************
`define DEID_PIDX_DIAG_INTERRUPT_ENABLE     3'h0
`define DEID_PIDX_DELAY0      3'h1
`define DEID_PIDX_DELAY1      3'h2
`define DEID_PIDX_RISE_EN     3'h3
`define DEID_PIDX_FALL_EN     3'h4

// ***********************************************
// Parameter reset values and codes
// ***********************************************
`define DEID_RST_DIAG_INTERRUPT_ENABLE      8'h00
`define DEID_RST_DELAY        8'h02
`define DEID_RST_EDGE_EN      8'h00
`define DEID_DIAG_OFF         8'h00
`define DEID_DIAG_ON          8'h40
`define DEID_DLY_1US          8'h00
`define DEID_DLY_3US          8'h02
`define DEID_DLY_10US         8'h04
`define DEID_DLY_86US         8'h07
`define DEID_DLY_342US        8'h09
`define DEID_DLY_2731US       8'h0c

// ***********************************************
// Timing
// ***********************************************
`define DEID_CLK_MHZ          19'h64
`define DEID_US_CYC           7'h64
`define DEID_T_1US            19'h1
`define DEID_T_3US            19'h3
`define DEID_T_10US           19'ha
`define DEID_T_86US           19'h56
`define DEID_T_342US          19'h156
`define DEID_T_2731US         19'haab

// ***********************************************
// Diagnostic record byte indices
// ***********************************************
`define DEID_RIDX_SUMMARY     5'h00
`define DEID_RIDX_CLASS       5'h01
`define DEID_RIDX_RSVD_C      5'h02
`define DEID_RIDX_INTERNAL    5'h03
`define DEID_RIDX_CHKIND      5'h04
`define DEID_RIDX_BITS        5'h05
`define DEID_RIDX_CHCOUNT     5'h06
`define DEID_RIDX_CHFAULT     5'h07
`define DEID_RIDX_TS0         5'h10
`define DEID_RIDX_TS3         5'h13
`define DEID_SHORT_LAST       5'h03

// ***********************************************
// Fixed record values and bit positions
// ***********************************************
`define DEID_CLASS_INFO       8'h1f
`define DEID_CHANNEL_KIND     8'h70
`define DEID_BITS_PER_CH      8'h00
`define DEID_CHANNEL_COUNT    8'h02
`define DEID_SUM_MOD_FAIL     0
`define DEID_SUM_EXT_ERR      2
`define DEID_SUM_CH_ERR       3
`define DEID_INT_OVERFLOW     3
`define DEID_INT_LOST         6
`define DEID_DIAG_INTERRUPT_ENABLE_BIT      6

`endif

// file: tb/deid_chk_sva.sv
// Port assertions for the edge interrupt and diagnostic block
// Assumes bind onto deid_edge_irq_diag, one clock, sync reset
`default_nettype none
module deid_chk (
    input wire logic        sys_clk,
    input wire logic        sys_rst,
    input wire logic        proc_irq_ack,
    input wire logic        rec_rd_en,
    input wire logic        rec_long,
    input wire logic [4:0]  rec_idx,
    input wire logic [1:0]  input_state_ff,
    input wire logic        proc_irq_pend_ff,
    input wire logic [7:0]  proc_irq_source_ff,
    input wire logic [7:0]  proc_irq_input_snapshot_ff,
    input wire logic [15:0] proc_irq_timestamp_ff,
    input wire logic        diag_incoming_ff,
    input wire logic        diag_going_ff,
    input wire logic        module_fault_led_ff,
    input wire logic [7:0]  rec_rdata_ff,
    input wire logic        rec_valid_ff,
    input wire logic        rec_err_ff,
    input wire logic [31:0] ticker_ff
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****
    // Checks
    // ****
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    rec_answer_a: assert property (rec_rd_en |=> rec_valid_ff)
        else $error("record read not answered");
    short_refuse_a: assert property (rec_rd_en && !rec_long
        && rec_idx > 5'h03 |=> rec_err_ff && rec_rdata_ff == 8'h00)
        else $error("short read past byte 3 not refused");
    class_info_a: assert property (rec_rd_en && rec_idx == 5'h01
        |=> rec_rdata_ff == 8'h1f) else $error("class byte wrong");
    chan_kind_a: assert property (rec_rd_en && rec_long
        && rec_idx == 5'h04 |=> rec_rdata_ff == 8'h70)
        else $error("channel kind byte wrong");
    ticker_step_a: assert property (!$past(sys_rst)
        && ticker_ff != $past(ticker_ff)
        |-> ticker_ff == $past(ticker_ff) + 32'h1)
        else $error("ticker skipped a count");
    irq_stamp_a: assert property ($rose(proc_irq_pend_ff)
        |-> {16'h0, proc_irq_timestamp_ff}
        == ($past(ticker_ff) & 32'h0000ffff))
        else $error("record timestamp wrong");
    irq_source_a: assert property ($rose(proc_irq_pend_ff)
        |-> proc_irq_source_ff[1:0] != 2'b00
        && proc_irq_source_ff[7:2] == 6'h00)
        else $error("record source byte wrong");
    irq_snap_a: assert property ($rose(proc_irq_pend_ff)
        |-> proc_irq_input_snapshot_ff == {6'h00, input_state_ff})
        else $error("record snapshot wrong");
    pend_keep_a: assert property (proc_irq_pend_ff && !proc_irq_ack
        |=> proc_irq_pend_ff && $stable(proc_irq_source_ff))
        else $error("pending record overwritten");
    led_drop_a: assert property (module_fault_led_ff
        && !proc_irq_pend_ff |=> !proc_irq_pend_ff)
        else $error("edge recorded during diagnostic");
    led_window_a: assert property ($rose(module_fault_led_ff)
        |-> diag_incoming_ff) else $error("fault led without notice");
    going_off_a: assert property (diag_going_ff
        |-> !module_fault_led_ff ##1 !diag_going_ff)
        else $error("going notice wrong");
endmodule // deid_chk

bind deid_edge_irq_diag deid_chk u_chk (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .proc_irq_ack(proc_irq_ack),
    .rec_rd_en(rec_rd_en), .rec_long(rec_long), .rec_idx(rec_idx),
    .input_state_ff(input_state_ff), .proc_irq_pend_ff(proc_irq_pend_ff),
    .proc_irq_source_ff(proc_irq_source_ff),
    .proc_irq_input_snapshot_ff(proc_irq_input_snapshot_ff),
    .proc_irq_timestamp_ff(proc_irq_timestamp_ff),
    .diag_incoming_ff(diag_incoming_ff), .diag_going_ff(diag_going_ff),
    .module_fault_led_ff(module_fault_led_ff),
    .rec_rdata_ff(rec_rdata_ff), .rec_valid_ff(rec_valid_ff),
    .rec_err_ff(rec_err_ff), .ticker_ff(ticker_ff)
);
`default_nettype wire

// file: tb/deid_host.sv
// Head station model: parameter writes, record reads, acknowledges
// Assumes the block's host ports on sys_clk
`default_nettype none
module deid_host (
    input  wire logic       sys_clk,
    output var  logic       param_wr_en,
    output var  logic [2:0] param_idx,
    output var  logic [7:0] param_wdata,
    output var  logic       proc_irq_ack,
    output var  logic       diag_ack,
    output var  logic       rec_rd_en,
    output var  logic       rec_long,
    output var  logic [4:0] rec_idx,
    input  wire logic [7:0] rec_rdata_ff,
    input  wire logic       rec_valid_ff,
    input  wire logic       rec_err_ff
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        {param_wr_en, param_idx, param_wdata} = 12'h0;
        {proc_irq_ack, diag_ack, rec_rd_en, rec_long, rec_idx} = 9'h0;
    end
    // Diag enable written mid-run in t_diag; delays from code set plus unused code 05h
    task automatic wr(input logic [2:0] i, input logic [7:0] d);
        @(posedge sys_clk);
        param_wr_en <= 1'b1;
        param_idx   <= i;
        param_wdata <= d;
        @(posedge sys_clk);
        param_wr_en <= 1'b0;
    endtask
    task automatic rd(input logic l, input logic [4:0] i,
        output logic [7:0] d, output logic e, output logic v);
        @(posedge sys_clk);
        rec_rd_en <= 1'b1;
        rec_long  <= l;
        rec_idx   <= i;
        @(posedge sys_clk);
        rec_rd_en <= 1'b0;
        #1;
        d = rec_rdata_ff;
        e = rec_err_ff;
        v = rec_valid_ff;
    endtask
    task automatic ack(input logic dg);
        @(posedge sys_clk);
        diag_ack     <= dg;
        proc_irq_ack <= !dg;
        @(posedge sys_clk);
        diag_ack     <= 1'b0;
        proc_irq_ack <= 1'b0;
    endtask
endmodule // deid_host
`default_nettype wire

// file: tb/deid_edge_irq_diag_tb.sv
// Self-checking bench for the edge interrupt and diagnostic block
// Assumes deid_host drives the host side, bench drives field inputs
`default_nettype none
module deid_edge_irq_diag_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk, sys_rst, param_wr_en, proc_irq_ack, diag_ack;
    logic        rec_rd_en, rec_long, proc_irq_pend_ff, diag_incoming_ff;
    logic        diag_going_ff, module_fault_led_ff, rec_valid_ff;
    logic        rec_err_ff;
    logic [1:0]  input_channel, input_state_ff;
    logic [2:0]  param_idx;
    logic [4:0]  rec_idx;
    logic [7:0]  param_wdata, proc_irq_source_ff, rec_rdata_ff;
    logic [7:0]  proc_irq_input_snapshot_ff;
    logic [15:0] proc_irq_timestamp_ff;
    logic [31:0] ticker_ff;
    int          num_errors, cmp_count, edges;
    deid_edge_irq_diag #(.DLY_86US_CYC(19'd20), .DLY_342US_CYC(19'd40),
        .DLY_2731US_CYC(19'd60), .US_CYC(7'd100)) DUT (.sys_clk, .sys_rst,
        .input_channel, .param_wr_en, .param_idx, .param_wdata,
        .proc_irq_ack, .diag_ack, .rec_rd_en, .rec_long, .rec_idx,
        .input_state_ff, .proc_irq_pend_ff, .proc_irq_source_ff,
        .proc_irq_input_snapshot_ff, .proc_irq_timestamp_ff,
        .diag_incoming_ff, .diag_going_ff, .module_fault_led_ff,
        .rec_rdata_ff, .rec_valid_ff, .rec_err_ff, .ticker_ff);
    deid_host u_host (.sys_clk(sys_clk), .param_wr_en(param_wr_en),
        .param_idx(param_idx), .param_wdata(param_wdata),
        .proc_irq_ack(proc_irq_ack), .diag_ack(diag_ack),
        .rec_rd_en(rec_rd_en), .rec_long(rec_long), .rec_idx(rec_idx),
        .rec_rdata_ff(rec_rdata_ff), .rec_valid_ff(rec_valid_ff),
        .rec_err_ff(rec_err_ff));
    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) edges <= sys_rst ? 0 : edges + 1;
    // ****
    // Helpers
    // ****
    task automatic check(input string nm, input logic [31:0] seen, exp);
        cmp_count++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic conclude;
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic wait_on(input logic led, output int n);
        n = 0;
        while ((led ? module_fault_led_ff : proc_irq_pend_ff) !== 1'b1)
        begin
            @(posedge sys_clk);
            #1;
            n++;
            if (n > 3000)
            begin
                num_errors++;
                conclude();
            end
        end
    endtask
    task automatic rd_chk(input logic l, input logic [4:0] i,
        input logic [7:0] exp, input logic ee);
        logic [7:0] d;
        logic e, v;
        u_host.rd(l, i, d, e, v);
        check("rec_valid", v, 1'b1);
        check("rec_err", e, ee);
        check("rec_byte", d, exp);
    endtask
    task automatic drive(input logic [1:0] v, input logic hold);
        @(posedge sys_clk);
        input_channel <= v;
        if (hold)
            repeat (150) @(posedge sys_clk);
        #1;
    endtask
    // ****
    // Scenarios
    // ****
    task automatic t_reset;
        logic [4:0] ix [9] = '{0, 1, 2, 4, 5, 6, 7, 3, 5'h13};
        logic [7:0] ex [9] = '{0, 8'h1f, 0, 8'h70, 0, 8'h02, 0, 0, 0};
        for (int k = 0; k < 9; k++)
            rd_chk(1'b1, ix[k], ex[k], 1'b0);
        rd_chk(1'b0, 5'h03, 8'h00, 1'b0);
        rd_chk(1'b0, 5'h04, 8'h00, 1'b1);
        rd_chk(1'b1, 5'h14, 8'h00, 1'b1);
    endtask
    task automatic t_delay;
        logic [7:0] cd [7] = '{8'h00, 8'h02, 8'h04, 8'h07, 8'h09,
            8'h0c, 8'h05};
        int cy [7] = '{100, 300, 1000, 20, 40, 60, 60};
        int n;
        u_host.wr(3'h3, 8'h01);
        u_host.wr(3'h4, 8'h01);
        for (int k = 0; k < 7; k++)
        begin
            u_host.wr(3'h1, cd[k]);
            drive(input_channel ^ 2'b01, 1'b0);
            wait_on(1'b0, n);
            check("delay", n >= cy[k] && n <= cy[k] + 4, 1'b1);
            check("source", proc_irq_source_ff, 8'h01);
            check("snap", proc_irq_input_snapshot_ff, input_channel);
            u_host.ack(1'b0);
        end
    endtask
    task automatic t_mask;
        int n;
        u_host.wr(3'h2, 8'h00);
        drive(2'b11, 1'b1);
        check("masked", proc_irq_pend_ff, 1'b0);
        u_host.wr(3'h4, 8'hff);
        drive(2'b01, 1'b0);
        wait_on(1'b0, n);
        check("source", proc_irq_source_ff, 8'h02);
        u_host.ack(1'b0);
        u_host.wr(3'h3, 8'h03);
        u_host.wr(3'h1, 8'h00);
        drive(2'b10, 1'b0);
        wait_on(1'b0, n);
        check("source", proc_irq_source_ff, 8'h03);
        check("snap", proc_irq_input_snapshot_ff, 8'h02);
        u_host.ack(1'b0);
    endtask
    task automatic t_diag;
        int n;
        u_host.wr(3'h0, 8'h41);
        drive(2'b00, 1'b0);
        wait_on(1'b0, n);
        drive(2'b01, 1'b1);
        check("kept", proc_irq_source_ff, 8'h02);
        rd_chk(1'b1, 5'h03, 8'h00, 1'b0);
        u_host.ack(1'b0);
        u_host.wr(3'h0, 8'h40);
        drive(2'b00, 1'b0);
        wait_on(1'b0, n);
        drive(2'b01, 1'b0);
        wait_on(1'b1, n);
        check("kept", proc_irq_source_ff, 8'h01);
        rd_chk(1'b1, 5'h03, 8'h40, 1'b0);
        rd_chk(1'b1, 5'h07, 8'h01, 1'b0);
        rd_chk(1'b1, 5'h00, 8'h08, 1'b0);
        u_host.ack(1'b0);
        drive(2'b00, 1'b1);
        check("dropped", proc_irq_pend_ff, 1'b0);
        u_host.ack(1'b1);
        repeat (3) @(posedge sys_clk);
        #1;
        check("led", module_fault_led_ff, 1'b0);
        rd_chk(1'b1, 5'h03, 8'h00, 1'b0);
    endtask
    initial
    begin
        num_errors = 0;
        cmp_count = 0;
        sys_rst = 1'b1;
        input_channel = 2'b00;
        repeat (4) @(posedge sys_clk);
        sys_rst <= 1'b0;
        t_reset();
        t_delay();
        t_mask();
        t_diag();
        check("ticker", ticker_ff, 32'(edges / 100));
        conclude();
    end
endmodule // deid_edge_irq_diag_tb
`default_nettype wire
